/* File: shared/wdt_pkg.sv */
// Purpose: Shared constants for the watchdog and reset-source block
// Assumes: APB offsets are byte addresses, one 32-bit word per register
// Notes: Timing figures are given in their own units and derived here
package wdt_pkg;
   // Register byte offsets
   localparam logic [7:0] WDT_CTRL_OFFSET = 8'h00;
   localparam logic [7:0] FLAG_CTRL_OFFSET = 8'h04;
   localparam logic [7:0] LEVEL_CFG_OFFSET = 8'h08;
   localparam logic [7:0] STATUS_OFFSET = 8'h0C;
   // Values after power-on
   localparam logic [7:0] WDT_CTRL_POR = 8'h53;
   localparam logic [7:0] LEVEL_CFG_POR = 8'h55;
   // Key field codes and positions
   localparam logic [4:0] KEY_DISABLE = 5'h15;
   localparam logic [4:0] KEY_ENABLE = 5'h0A;
   localparam int KEY_MSB = 7;
   localparam int KEY_LSB = 3;
   localparam int PERIOD_MSB = 2;
   // Level codes
   localparam logic [7:0] LEVEL_2V10 = 8'h55;
   localparam logic [7:0] LEVEL_2V55 = 8'h33;
   localparam logic [7:0] LEVEL_3V15 = 8'h99;
   localparam logic [7:0] LEVEL_3V80 = 8'hAA;
   // Flag register bit positions
   localparam int FLAG_SYSCLK_BIT = 7;
   localparam int FLAG_LVR_BIT = 2;
   localparam int FLAG_LEVEL_BIT = 1;
   localparam int FLAG_KEY_BIT = 0;
   // Status register bit positions
   localparam int STAT_TIMEOUT_BIT = 0;
   localparam int STAT_POWERDOWN_BIT = 1;
   // Reset cause index
   localparam int CAUSE_KEY = 0;
   localparam int CAUSE_LEVEL = 1;
   localparam int CAUSE_LVR = 2;
   localparam int CAUSE_WDT = 3;
   // Reset delay in RC ticks, gives 2 to 3 RC periods
   localparam logic [1:0] RESET_DELAY_TICKS = 2'h3;
   // Low-voltage qualification time
   localparam int CLOCK_PERIOD_NS = 40;
   localparam int LVR_MIN_NS = 100000;
   localparam logic [11:0] LVR_MIN_CYCLES =
      12'((LVR_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
   localparam int COUNT_WIDTH = 18;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_WAIT = 2'b01,
      SEQ_FIRE = 2'b10
   } seq_state_type;

   // Last count before overflow for each period code
   function automatic logic [17:0] period_limit(input logic [2:0] p);
      case (p)
         3'h0: period_limit = 18'h000FF;
         3'h1: period_limit = 18'h003FF;
         3'h2: period_limit = 18'h00FFF;
         3'h3: period_limit = 18'h03FFF;
         3'h4: period_limit = 18'h07FFF;
         3'h5: period_limit = 18'h0FFFF;
         3'h6: period_limit = 18'h1FFFF;
         default: period_limit = 18'h3FFFF;
      endcase
   endfunction
endpackage

/* File: shared/wdt_link_if.sv */
// Purpose: Carrier between the controller and the watchdog counter
// Assumes: Single clock domain
// Notes: None
`timescale 1ns/100ps
interface wdt_link_if;
   logic tick;
   logic clear;
   logic enable;
   logic [2:0] period;
   logic overflow;
   logic [17:0] count;
   modport ctl(output tick, clear, enable, period,
               input overflow, count);
   modport cnt(input tick, clear, enable, period,
               output overflow, count);
endinterface

/* File: hw/wdt_counter.sv */
// Purpose: Watchdog count on source-clock ticks
// Assumes: tick is a one-cycle pulse per source-clock period
// Notes: Overflow is a one-cycle pulse, count restarts from zero
`timescale 1ns/100ps
module wdt_counter (
   input wire logic clock,
   input wire logic rst,
   wdt_link_if.cnt link
);
   logic [17:0] count_reg;
   logic [17:0] count_next;
   wire logic [17:0] limit = wdt_pkg::period_limit(link.period);
   wire logic step = link.tick & link.enable;
   wire logic at_limit = count_reg == limit;

   assign link.overflow = step & at_limit; // R24
   assign link.count = count_reg;
   assign count_next = link.clear ? 18'h00000 : // R10
      (!step ? count_reg : (at_limit ? 18'h00000 : count_reg + 18'h00001));

   always_ff @(posedge clock) begin
      if (rst) begin
         count_reg <= 18'h00000;
      end else begin
         count_reg <= count_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   a_period_limit: assert property (@(posedge clock) disable iff (rst) // R2
      link.overflow |-> count_reg == wdt_pkg::period_limit(link.period))
      else $error("Overflow at wrong count");
   a_clear_restart: assert property (@(posedge clock) disable iff (rst) // R10
      link.clear |=> count_reg == 18'h00000)
      else $error("Clear did not restart count");
   a_disable_hold: assert property (@(posedge clock) disable iff (rst) // R3
      !link.enable && !link.clear |=> $stable(count_reg))
      else $error("Count moved while disabled");
endmodule // wdt_counter

/* File: hw/wdt_reset_ctrl.sv */
// Purpose: Watchdog and reset-source logic with APB registers
// Assumes: Tick and instruction inputs are one-cycle pulses
// Notes: rst is the power-on reset
// How it works
// [R1] Source tick chosen by fixed option
// [R2] Period code sets timeout 2^8 to 2^18
// [R3] Key 10101 disables counting and timeouts
// [R4] Key 01010 enables the watchdog
// [R5] Other key resets after 2-3 RC cycles
// [R6] Key fault flag sticky until software clears
// [R7] Control register powers up as 0x53
// [R8] Normal overflow resets and sets timeout
// [R9] Sleep overflow resets PC/SP, sets timeout
// [R10] Count cleared by key reset, clear, halt
// [R11] Software clears watchdog before timeout
// [R12] Low supply must persist before resetting
// [R13] Level field selects four thresholds
// [R14] Valid level: delayed reset, contents kept
// [R15] Bad level: reset, reload, fault flag
// [R16] Level register powers up as 0x55
// [R17] Low-voltage flag sticky until software clears
// [R18] Level fault flag set on bad code
// [R19] Low-voltage reset off while powered down
// [R20] Unused flag bits read as zero
// [R21] Power-on clears PC, ports high
// [R22] Timeout/powerdown flags per reset type
// [R23] Powerdown flag cleared by clear, set by halt
// [R24] Free counter overflows at selected ratio
`timescale 1ns/100ps
module wdt_reset_ctrl #(
   parameter bit USE_CRYSTAL = 1'b0
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic crystal_tick,
   input wire logic rc_tick,
   input wire logic clear_watchdog_instruction,
   input wire logic halt_instruction,
   input wire logic sleep_mode,
   input wire logic lowvolt_detect,
   output logic full_reset,
   output logic pc_sp_reset,
   output logic pc_clear,
   output logic port_init_high,
   output logic [1:0] lowvolt_threshold,
   output logic idle_sysclk_keep,
   output logic timeout_status_flag,
   output logic powerdown_status_flag
);
   ////////////////////////////////////////////////////////////////////
   // Register state
   logic [7:0] watchdog_control_reg;
   logic [7:0] lowvolt_level_config_reg;
   logic idle_sysclk_keep_reg;
   logic lowvolt_reset_flag_reg;
   logic lowvolt_level_fault_flag_reg;
   logic wdt_key_fault_flag_reg;
   logic timeout_status_flag_reg;
   logic powerdown_status_flag_reg;
   logic [31:0] prdata_reg;
   logic [31:0] read_value;
   logic mapped;
   wdt_pkg::seq_state_type state_reg;
   wdt_pkg::seq_state_type state_next;
   logic [1:0] delay_reg;
   logic [3:0] cause_reg;
   logic [11:0] lv_count_reg;
   logic pc_sp_reset_reg;
   logic port_init_reg;
   wdt_link_if link ();

   ////////////////////////////////////////////////////////////////////
   // APB decode
   wire logic access = psel & penable;
   wire logic wr_en = access & pwrite;
   wire logic rd_setup = psel & ~penable & ~pwrite;
   wire logic hit_ctrl = paddr == wdt_pkg::WDT_CTRL_OFFSET;
   wire logic hit_flag = paddr == wdt_pkg::FLAG_CTRL_OFFSET;
   wire logic hit_level = paddr == wdt_pkg::LEVEL_CFG_OFFSET;
   wire logic hit_stat = paddr == wdt_pkg::STATUS_OFFSET;
   wire logic ctrl_wr = wr_en & hit_ctrl;
   wire logic flag_wr = wr_en & hit_flag;
   wire logic level_wr = wr_en & hit_level;

   always_comb begin
      read_value = 32'h00000000;
      mapped = 1'b1;
      if (hit_ctrl) begin
         read_value[7:0] = watchdog_control_reg;
      end else if (hit_flag) begin
         read_value[wdt_pkg::FLAG_SYSCLK_BIT] = idle_sysclk_keep_reg;
         read_value[wdt_pkg::FLAG_LVR_BIT] = lowvolt_reset_flag_reg;
         read_value[wdt_pkg::FLAG_LEVEL_BIT] =
            lowvolt_level_fault_flag_reg;
         read_value[wdt_pkg::FLAG_KEY_BIT] = wdt_key_fault_flag_reg;
      end else if (hit_level) begin
         read_value[7:0] = lowvolt_level_config_reg;
      end else if (hit_stat) begin
         read_value[wdt_pkg::STAT_TIMEOUT_BIT] = timeout_status_flag_reg;
         read_value[wdt_pkg::STAT_POWERDOWN_BIT] =
            powerdown_status_flag_reg;
      end else begin
         mapped = 1'b0;
      end
   end // R20

   assign pready = 1'b1;
   assign pslverr = access & ~mapped;
   assign prdata = prdata_reg;

   always_ff @(posedge clock) begin
      if (rst) begin
         prdata_reg <= 32'h00000000;
      end else if (rd_setup) begin
         prdata_reg <= read_value;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Key and level decode
   wire logic [4:0] key =
      watchdog_control_reg[wdt_pkg::KEY_MSB:wdt_pkg::KEY_LSB];
   wire logic key_off = key == wdt_pkg::KEY_DISABLE; // R3
   wire logic key_on = key == wdt_pkg::KEY_ENABLE; // R4
   wire logic key_bad = ~key_off & ~key_on; // R5
   wire logic [7:0] lvl = lowvolt_level_config_reg;
   wire logic lvl_a = lvl == wdt_pkg::LEVEL_2V10;
   wire logic lvl_b = lvl == wdt_pkg::LEVEL_2V55;
   wire logic lvl_c = lvl == wdt_pkg::LEVEL_3V15;
   wire logic lvl_d = lvl == wdt_pkg::LEVEL_3V80;
   wire logic level_ok = lvl_a | lvl_b | lvl_c | lvl_d;
   wire logic level_bad = ~level_ok; // R15

   assign lowvolt_threshold = lvl_d ? 2'h3 :
      (lvl_c ? 2'h2 : (lvl_b ? 2'h1 : 2'h0)); // R13

   ////////////////////////////////////////////////////////////////////
   // Watchdog counter link
   wire logic seq_idle = state_reg == wdt_pkg::SEQ_IDLE;
   wire logic seq_fire = state_reg == wdt_pkg::SEQ_FIRE;
   wire logic instr_clear = clear_watchdog_instruction | halt_instruction;

   assign link.tick = USE_CRYSTAL ? crystal_tick : rc_tick; // R1
   assign link.period = watchdog_control_reg[wdt_pkg::PERIOD_MSB:0]; // R2
   assign link.enable = key_on & seq_idle; // R3 R4
   assign link.clear = instr_clear | key_bad | seq_fire; // R10 R11

   wdt_counter counter (
      .clock(clock),
      .rst(rst),
      .link(link)
   );

   wire logic ovf_sleep = link.overflow & sleep_mode; // R9
   wire logic ovf_normal = link.overflow & ~sleep_mode; // R8

   ////////////////////////////////////////////////////////////////////
   // Low-voltage qualification
   wire logic lv_full = lv_count_reg == wdt_pkg::LVR_MIN_CYCLES;
   wire logic lv_run = lowvolt_detect & ~sleep_mode; // R19
   wire logic lvr_hit = lv_run & lv_full & level_ok; // R12 R14

   always_ff @(posedge clock) begin
      if (rst || !lv_run) begin
         lv_count_reg <= 12'h000;
      end else if (!lv_full) begin
         lv_count_reg <= lv_count_reg + 12'h001; // R12
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Reset sequencer
   logic [3:0] cause_new;
   always_comb begin
      cause_new = 4'h0;
      cause_new[wdt_pkg::CAUSE_KEY] = key_bad;
      cause_new[wdt_pkg::CAUSE_LEVEL] = level_bad;
      cause_new[wdt_pkg::CAUSE_LVR] = lvr_hit;
      cause_new[wdt_pkg::CAUSE_WDT] = ovf_normal;
   end

   wire logic delay_done = rc_tick &
      (delay_reg == wdt_pkg::RESET_DELAY_TICKS - 2'h1);
   wire logic fire_go = (state_reg == wdt_pkg::SEQ_WAIT) & delay_done;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         wdt_pkg::SEQ_IDLE: begin
            if (|cause_new) begin
               state_next = wdt_pkg::SEQ_WAIT;
            end
         end
         wdt_pkg::SEQ_WAIT: begin
            if (delay_done) begin
               state_next = wdt_pkg::SEQ_FIRE; // R5 R14 R15
            end
         end
         default: begin
            state_next = wdt_pkg::SEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= wdt_pkg::SEQ_IDLE;
         delay_reg <= 2'h0;
         cause_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         if (state_reg != wdt_pkg::SEQ_WAIT) begin
            delay_reg <= 2'h0;
         end else if (rc_tick) begin
            delay_reg <= delay_reg + 2'h1;
         end
         if (seq_fire) begin
            cause_reg <= 4'h0;
         end else if (!seq_idle || |cause_new) begin
            cause_reg <= cause_reg | cause_new;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge clock) begin
      if (rst) begin
         watchdog_control_reg <= wdt_pkg::WDT_CTRL_POR; // R7
      end else if (seq_fire) begin
         watchdog_control_reg <= wdt_pkg::WDT_CTRL_POR;
      end else if (ctrl_wr) begin
         watchdog_control_reg <= pwdata[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         lowvolt_level_config_reg <= wdt_pkg::LEVEL_CFG_POR; // R16
      end else if (seq_fire && cause_reg[wdt_pkg::CAUSE_LEVEL]) begin
         lowvolt_level_config_reg <= wdt_pkg::LEVEL_CFG_POR; // R15
      end else if (level_wr) begin
         lowvolt_level_config_reg <= pwdata[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         idle_sysclk_keep_reg <= 1'b0;
      end else if (flag_wr) begin
         idle_sysclk_keep_reg <= pwdata[wdt_pkg::FLAG_SYSCLK_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sticky reset-cause flags, a set wins over a clearing write
   wire logic key_set = fire_go & cause_reg[wdt_pkg::CAUSE_KEY];
   wire logic lvr_set = fire_go & cause_reg[wdt_pkg::CAUSE_LVR];
   wire logic wdt_set = fire_go & cause_reg[wdt_pkg::CAUSE_WDT];

   always_ff @(posedge clock) begin
      if (rst) begin
         wdt_key_fault_flag_reg <= 1'b0;
         lowvolt_reset_flag_reg <= 1'b0;
         lowvolt_level_fault_flag_reg <= 1'b0;
      end else begin
         wdt_key_fault_flag_reg <= key_set | (flag_wr ? // R6
            pwdata[wdt_pkg::FLAG_KEY_BIT] : wdt_key_fault_flag_reg);
         lowvolt_reset_flag_reg <= lvr_set | (flag_wr ? // R17
            pwdata[wdt_pkg::FLAG_LVR_BIT] : lowvolt_reset_flag_reg);
         lowvolt_level_fault_flag_reg <= level_bad | (flag_wr ? // R18
            pwdata[wdt_pkg::FLAG_LEVEL_BIT] :
            lowvolt_level_fault_flag_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Timeout and power-down status
   always_ff @(posedge clock) begin
      if (rst) begin
         timeout_status_flag_reg <= 1'b0; // R22
         powerdown_status_flag_reg <= 1'b0;
      end else begin
         if (wdt_set || ovf_sleep) begin
            timeout_status_flag_reg <= 1'b1; // R8 R9 R22
         end else if (instr_clear) begin
            timeout_status_flag_reg <= 1'b0;
         end
         if (ovf_sleep || halt_instruction) begin
            powerdown_status_flag_reg <= 1'b1; // R22 R23
         end else if (clear_watchdog_instruction) begin
            powerdown_status_flag_reg <= 1'b0; // R23
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Reset outputs
   always_ff @(posedge clock) begin
      if (rst) begin
         pc_sp_reset_reg <= 1'b0;
         port_init_reg <= 1'b1; // R21
      end else begin
         pc_sp_reset_reg <= ovf_sleep; // R9
         port_init_reg <= fire_go;
      end
   end

   assign full_reset = seq_fire; // R5 R8
   assign pc_sp_reset = pc_sp_reset_reg;
   assign pc_clear = port_init_reg | pc_sp_reset_reg; // R21
   assign port_init_high = port_init_reg; // R21
   assign idle_sysclk_keep = idle_sysclk_keep_reg;
   assign timeout_status_flag = timeout_status_flag_reg;
   assign powerdown_status_flag = powerdown_status_flag_reg;

   ////////////////////////////////////////////////////////////////////
   // Checks
   a_fire_delay: assert property (@(posedge clock) disable iff (rst) // R5
      $rose(full_reset) |-> $past(delay_reg) == 2'h2 && $past(rc_tick))
      else $error("Reset fired without RC delay");
   a_key_flag_set: assert property (@(posedge clock) disable iff (rst) // R6
      full_reset && cause_reg[wdt_pkg::CAUSE_KEY]
      |-> wdt_key_fault_flag_reg)
      else $error("Key fault flag not set");
   a_lvr_flag_keep: assert property (@(posedge clock) disable iff (rst) // R17
      lowvolt_reset_flag_reg && !flag_wr |=> lowvolt_reset_flag_reg)
      else $error("Low-voltage flag lost");
   a_level_reload: assert property (@(posedge clock) disable iff (rst) // R15
      full_reset && cause_reg[wdt_pkg::CAUSE_LEVEL]
      |=> lowvolt_level_config_reg == 8'h55)
      else $error("Level register not reloaded");
   a_sleep_timeout: assert property (@(posedge clock) disable iff (rst) // R9
      link.overflow && sleep_mode |=> pc_sp_reset
      && timeout_status_flag && powerdown_status_flag)
      else $error("Sleep timeout mishandled");
   a_lvr_filter: assert property (@(posedge clock) disable iff (rst) // R12
      $rose(cause_reg[wdt_pkg::CAUSE_LVR])
      |-> $past(lv_count_reg) == wdt_pkg::LVR_MIN_CYCLES)
      else $error("Low-voltage reset not qualified");
   a_pd_lvr_off: assert property (@(posedge clock) disable iff (rst) // R19
      sleep_mode |=> lv_count_reg == 12'h000)
      else $error("Low-voltage filter ran in power-down");
   a_halt_flags: assert property (@(posedge clock) disable iff (rst) // R23 R10
      halt_instruction && !link.overflow && !fire_go
      |=> powerdown_status_flag && !timeout_status_flag
      && link.count == 18'h00000)
      else $error("Halt flags wrong");
   a_level_flag: assert property (@(posedge clock) disable iff (rst) // R18
      level_bad |=> lowvolt_level_fault_flag_reg)
      else $error("Level fault flag not set");
endmodule // wdt_reset_ctrl

/* File: tb/wdt_reset_ctrl_tb.sv */
// Purpose: Self-checking bench for the watchdog and reset-source block
// Assumes: RC tick every second clock, crystal source not selected
// Notes: Registers reached through APB tasks, expectations from the rules
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
fails++; $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module wdt_reset_ctrl_tb;
   logic clock = 1'h0;
   logic rst = 1'h1;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic crystal_tick = 1'h0;
   logic rc_tick = 1'h0;
   logic rc_tog = 1'h0;
   logic clear_watchdog_instruction = 1'h0;
   logic halt_instruction = 1'h0;
   logic sleep_mode = 1'h0;
   logic lowvolt_detect = 1'h0;
   logic full_reset;
   logic pc_sp_reset;
   logic pc_clear;
   logic port_init_high;
   logic [1:0] lowvolt_threshold;
   logic idle_sysclk_keep;
   logic timeout_status_flag;
   logic powerdown_status_flag;
   int fails = 0;
   int num_checks = 0;
   int ticks;
   int cycles;
   int i;
   logic seen;
   logic fr_any;
   logic pih;
   logic er;
   logic [31:0] rd;
   logic [31:0] st;
   int lim[3] = '{256, 1024, 4096};
   logic [7:0] lv[4] = '{wdt_pkg::LEVEL_2V10, wdt_pkg::LEVEL_2V55,
      wdt_pkg::LEVEL_3V15, wdt_pkg::LEVEL_3V80};

   wdt_reset_ctrl #(.USE_CRYSTAL(1'h0)) dut (.clock(clock), .rst(rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .crystal_tick(crystal_tick), .rc_tick(rc_tick),
      .clear_watchdog_instruction(clear_watchdog_instruction),
      .halt_instruction(halt_instruction), .sleep_mode(sleep_mode),
      .lowvolt_detect(lowvolt_detect), .full_reset(full_reset),
      .pc_sp_reset(pc_sp_reset), .pc_clear(pc_clear),
      .port_init_high(port_init_high),
      .lowvolt_threshold(lowvolt_threshold),
      .idle_sysclk_keep(idle_sysclk_keep),
      .timeout_status_flag(timeout_status_flag),
      .powerdown_status_flag(powerdown_status_flag));

   ////////////////////////////////////////////////////////////////////////
   always #20 clock = ~clock;

   always @(posedge clock) begin
      rc_tog <= ~rc_tog;
      rc_tick <= rc_tog;
   end

   task automatic give_verdict();
      if (fails == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic apb(input logic [7:0] a, input logic w,
         input logic [31:0] wd, output logic [31:0] r, output logic e);
      int k;
      @(posedge clock);
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      psel <= 1'h1;
      penable <= 1'h0;
      @(posedge clock);
      penable <= 1'h1;
      for (k = 0; k < 16; k++) begin
         @(posedge clock);
         if (pready === 1'h1)
            break;
      end
      if (k == 16) begin
         fails++;
         give_verdict();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(a, 1'h1, d, r, e);
      @(negedge clock);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex,
         input string nm);
      logic [31:0] r;
      logic e;
      apb(a, 1'h0, 32'h0, r, e);
      `CHK(nm, ex, r)
   endtask

   task automatic wdt_off();
      wr(wdt_pkg::WDT_CTRL_OFFSET, 32'({wdt_pkg::KEY_DISABLE, 3'h0}));
   endtask

   task automatic instr(input logic is_halt);
      @(posedge clock);
      halt_instruction <= is_halt;
      clear_watchdog_instruction <= !is_halt;
      @(posedge clock);
      halt_instruction <= 1'h0;
      clear_watchdog_instruction <= 1'h0;
   endtask

   // Waits for full_reset, or pc_sp_reset, counting RC ticks meanwhile
   task automatic wait_ev(input int cyc, input logic must, input logic ps);
      int n;
      ticks = 0;
      seen = 1'h0;
      fr_any = 1'h0;
      for (n = 0; n < cyc && !seen; n++) begin
         @(posedge clock);
         if (full_reset === 1'h1)
            fr_any = 1'h1;
         if ((ps ? pc_sp_reset : full_reset) === 1'h1) begin
            seen = 1'h1;
            pih = port_init_high;
         end else if (rc_tick === 1'h1)
            ticks++;
      end
      cycles = n;
      if (must && !seen) begin
         fails++;
         give_verdict();
      end
   endtask

   initial begin
      #4000000;
      fails++;
      give_verdict();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clock);
      `CHK("port_init_high", 1'h1, port_init_high)
      `CHK("pc_clear", 1'h1, pc_clear)
      rst <= 1'h0;
      repeat (2) @(posedge clock);
      `CHK("pc_clear_off", 1'h0, pc_clear)
      rd_chk(wdt_pkg::WDT_CTRL_OFFSET, 32'h53, "ctrl_por");
      rd_chk(wdt_pkg::LEVEL_CFG_OFFSET, 32'h55, "level_por");
      rd_chk(wdt_pkg::FLAG_CTRL_OFFSET, 32'h0, "flags_por");
      rd_chk(wdt_pkg::STATUS_OFFSET, 32'h0, "status_por");
      apb(8'h10, 1'h0, 32'h0, rd, er);
      `CHK("unmapped_err", 1'h1, er)
      `CHK("unmapped_data", 32'h0, rd)
      wr(wdt_pkg::FLAG_CTRL_OFFSET, 32'hFF);
      rd_chk(wdt_pkg::FLAG_CTRL_OFFSET, 32'h87, "flags_rw");
      `CHK("sysclk_keep", 1'h1, idle_sysclk_keep)
      wr(wdt_pkg::FLAG_CTRL_OFFSET, 32'h0);
      rd_chk(wdt_pkg::FLAG_CTRL_OFFSET, 32'h0, "flags_clear");
      for (i = 0; i < 4; i++) begin
         wr(wdt_pkg::LEVEL_CFG_OFFSET, 32'(lv[i]));
         `CHK("threshold", 2'(i), lowvolt_threshold)
      end
      // Normal-mode overflow for the three shortest periods
      for (i = 0; i < 3; i++) begin
         wr(wdt_pkg::WDT_CTRL_OFFSET, 32'({wdt_pkg::KEY_ENABLE, 3'(i)}));
         instr(1'h0);
         wait_ev(20000, 1'h1, 1'h0);
         `CHK("period", 1'h1, ticks >= lim[i]+2 && ticks <= lim[i]+4)
         `CHK("ports_with_reset", 1'h1, pih)
         @(posedge clock);
         `CHK("reset_one_cycle", 1'h0, full_reset)
         rd_chk(wdt_pkg::STATUS_OFFSET, 32'h1, "status_wdt");
         rd_chk(wdt_pkg::WDT_CTRL_OFFSET, 32'h53, "ctrl_reload");
         wdt_off();
      end
      // Halt clears the count and marks power-down
      wr(wdt_pkg::WDT_CTRL_OFFSET, 32'({wdt_pkg::KEY_ENABLE, 3'h0}));
      instr(1'h1);
      @(negedge clock);
      `CHK("pdf_halt", 1'h1, powerdown_status_flag)
      `CHK("to_halt", 1'h0, timeout_status_flag)
      wait_ev(2000, 1'h1, 1'h0);
      `CHK("halt_count", 1'h1, ticks >= 258 && ticks <= 260)
      rd_chk(wdt_pkg::STATUS_OFFSET, 32'h3, "status_halt");
      wdt_off();
      instr(1'h0);
      @(negedge clock);
      `CHK("pdf_clear", 1'h0, powerdown_status_flag)
      // Periodic clearing keeps the watchdog quiet
      wr(wdt_pkg::WDT_CTRL_OFFSET, 32'({wdt_pkg::KEY_ENABLE, 3'h0}));
      for (i = 0; i < 3; i++) begin
         instr(1'h0);
         wait_ev(400, 1'h0, 1'h0);
         `CHK("kept_alive", 1'h0, seen)
      end
      // Overflow in sleep resets only PC and SP
      wr(wdt_pkg::WDT_CTRL_OFFSET, 32'({wdt_pkg::KEY_ENABLE, 3'h0}));
      @(posedge clock);
      sleep_mode <= 1'h1;
      instr(1'h0);
      wait_ev(2000, 1'h1, 1'h1);
      `CHK("sleep_full", 1'h0, fr_any)
      `CHK("sleep_count", 1'h1, ticks >= 255 && ticks <= 257)
      sleep_mode <= 1'h0;
      wdt_off();
      rd_chk(wdt_pkg::STATUS_OFFSET, 32'h3, "status_sleep");
      // Disabled watchdog never fires
      instr(1'h0);
      wait_ev(1200, 1'h0, 1'h0);
      `CHK("disabled", 1'h0, seen)
      // Bad key and bad level codes
      wr(wdt_pkg::WDT_CTRL_OFFSET, 32'hF8);
      wait_ev(100, 1'h1, 1'h0);
      `CHK("key_delay", 1'h1, ticks >= 2 && ticks <= 4)
      rd_chk(wdt_pkg::FLAG_CTRL_OFFSET, 32'h1, "key_flag");
      rd_chk(wdt_pkg::WDT_CTRL_OFFSET, 32'h53, "key_reload");
      wdt_off();
      rd_chk(wdt_pkg::FLAG_CTRL_OFFSET, 32'h1, "key_flag_kept");
      wr(wdt_pkg::LEVEL_CFG_OFFSET, 32'h12);
      wait_ev(100, 1'h1, 1'h0);
      `CHK("level_delay", 1'h1, ticks >= 2 && ticks <= 4)
      rd_chk(wdt_pkg::LEVEL_CFG_OFFSET, 32'h55, "level_reload");
      rd_chk(wdt_pkg::FLAG_CTRL_OFFSET, 32'h3, "level_flag");
      wdt_off();
      wr(wdt_pkg::FLAG_CTRL_OFFSET, 32'h0);
      // Low supply: short dip, qualified dip, power-down
      wr(wdt_pkg::LEVEL_CFG_OFFSET, 32'h99);
      apb(wdt_pkg::STATUS_OFFSET, 1'h0, 32'h0, st, er);
      lowvolt_detect <= 1'h1;
      wait_ev(1000, 1'h0, 1'h0);
      `CHK("short_dip", 1'h0, seen)
      lowvolt_detect <= 1'h0;
      repeat (4) @(posedge clock);
      lowvolt_detect <= 1'h1;
      wait_ev(3000, 1'h1, 1'h0);
      lowvolt_detect <= 1'h0;
      `CHK("lvr_time", 1'h1, cycles >= 2500 && cycles <= 2520)
      rd_chk(wdt_pkg::FLAG_CTRL_OFFSET, 32'h4, "lvr_flag");
      rd_chk(wdt_pkg::LEVEL_CFG_OFFSET, 32'h99, "level_kept");
      rd_chk(wdt_pkg::STATUS_OFFSET, st, "status_lvr");
      wdt_off();
      @(posedge clock);
      sleep_mode <= 1'h1;
      lowvolt_detect <= 1'h1;
      wait_ev(3000, 1'h0, 1'h0);
      `CHK("lvr_sleep", 1'h0, fr_any)
      sleep_mode <= 1'h0;
      lowvolt_detect <= 1'h0;
      give_verdict();
   end
endmodule // wdt_reset_ctrl_tb
